// ---- logic/fcl_defines.svh ----
// Offsets, field positions, factory contents and reserved masks of the fuse bytes.
// Assumes it is included by bare name from the fuse loader sources.
`ifndef FCL_DEFINES_SVH
`define FCL_DEFINES_SVH

`define FCL_OFS_WDT 4'h0
`define FCL_OFS_BOD 4'h1
`define FCL_OFS_OSC 4'h2
`define FCL_OFS_SYS0 4'h5

`define FCL_WDT_WINDOW 7:4
`define FCL_WDT_PERIOD 3:0
`define FCL_BOD_THRESHOLD 7:5
`define FCL_BOD_SAMPLE_RATE 4
`define FCL_BOD_ACTIVE 3:2
`define FCL_BOD_SLEEP 1:0
`define FCL_OSC_CLOCK_SOURCE 3:0
`define FCL_SYS_CRC_REGION 7:6
`define FCL_SYS_CRC_POLY 5
`define FCL_SYS_RESET_PIN 3
`define FCL_SYS_EEPROM_RETAIN 0

`define FCL_FACTORY_WDT 8'h00
`define FCL_FACTORY_BOD 8'h00
`define FCL_FACTORY_OSC 8'h00
`define FCL_FACTORY_SYS0 8'hc0

`define FCL_VALID_WDT 8'hff
`define FCL_VALID_BOD 8'hff
`define FCL_VALID_OSC 8'h0f
`define FCL_VALID_SYS0 8'he9

`define FCL_SKIP_CHECK 2'h3
`define FCL_READ_NONE 8'h00

`endif

// ---- logic/fcl_pkg.sv ----
// Types shared by the fuse loader modules.
// Assumes nothing beyond a SystemVerilog compiler.
package fcl_pkg;
    typedef logic [7:0] fcl_byte_t;
    typedef logic [3:0] fcl_addr_t;
    typedef enum logic [2:0] {
        FCL_ST_WDT = 3'h0,
        FCL_ST_BOD = 3'h1,
        FCL_ST_OSC = 3'h2,
        FCL_ST_SYS = 3'h3,
        FCL_ST_DONE = 3'h4
    } fcl_state_e;
endpackage : fcl_pkg

// ---- logic/fcl_fuse_byte.sv ----
// One nonvolatile fuse byte with its factory contents and reserved-bit mask.
// Assumes i_nv_init models the factory load; the byte is not touched by reset.
`timescale 1ns/100ps
module fcl_fuse_byte
    import fcl_pkg::*;
#(
    parameter fcl_byte_t FACTORY = 8'h00,
    parameter fcl_byte_t VALID_MASK = 8'hff,
    parameter fcl_addr_t ADDR = 4'h0
) (
    input wire logic i_ref_clk,
    input wire logic i_nv_init,
    input wire logic i_we,
    input wire fcl_addr_t i_addr,
    input wire fcl_byte_t i_wdata,
    output fcl_byte_t o_value
);
    generate
        if ((FACTORY & ~VALID_MASK) != 8'h00) begin : g_bad_factory
            $error("Factory contents set reserved bits.");
        end
    endgenerate

    wire logic hit = i_we && (i_addr == ADDR);
    wire fcl_byte_t masked = i_wdata & VALID_MASK;

    // Reserved bits are stored as zero whatever the programmer sends.
    always_ff @(posedge i_ref_clk) begin
        if (i_nv_init) begin
            o_value <= FACTORY;
        end else if (hit) begin
            o_value <= masked;
        end
    end
endmodule : fcl_fuse_byte

// ---- logic/fcl_erase_ctrl.sv ----
// Decides whether a chip erase also erases the EEPROM.
// Assumes i_chip_erase is a one-cycle pulse from the erase logic.
`timescale 1ns/100ps
module fcl_erase_ctrl
    import fcl_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_chip_erase,
    input wire logic i_locked,
    input wire logic i_retain,
    output logic o_eeprom_erase
);
    wire logic erase_nxt = i_chip_erase && (i_locked || !i_retain);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_eeprom_erase <= 1'b0;
        end else begin
            o_eeprom_erase <= erase_nxt;
        end
    end

    property p_unlocked_erase;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_chip_erase && !i_locked) |=> (o_eeprom_erase == !$past(i_retain));
    endproperty
    a_unlocked_erase: assert property (p_unlocked_erase) else $error("EEPROM erase ignores retention.");

    property p_locked_erase;
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_chip_erase && i_locked) |=> o_eeprom_erase;
    endproperty
    a_locked_erase: assert property (p_locked_erase) else $error("Locked erase kept EEPROM.");

    property p_no_spurious_erase;
        @(posedge i_ref_clk) disable iff (i_rst)
        !i_chip_erase |=> !o_eeprom_erase;
    endproperty
    a_no_spurious_erase: assert property (p_no_spurious_erase) else $error("EEPROM erased without request.");
endmodule : fcl_erase_ctrl

// ---- logic/fcl_loader.sv ----
// Fuse storage, read ports and the start-up copy into peripheral control fields.
// Assumes programmer and CPU ports are synchronous to i_ref_clk and i_locked is stable.
`timescale 1ns/100ps
`include "fcl_defines.svh"

module fcl_loader
    import fcl_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_nv_init,
    input wire logic i_locked,
    input wire logic i_prog_we,
    input wire fcl_addr_t i_prog_addr,
    input wire fcl_byte_t i_prog_wdata,
    input wire logic i_prog_rd,
    input wire logic i_cpu_rd,
    input wire fcl_addr_t i_cpu_addr,
    input wire logic i_chip_erase,
    output fcl_byte_t o_prog_rdata,
    output fcl_byte_t o_cpu_rdata,
    output logic [3:0] o_wdt_window,
    output logic [3:0] o_wdt_period,
    output logic [2:0] o_brownout_threshold,
    output logic o_brownout_sample_rate,
    output logic [1:0] o_bod_active_mode,
    output logic [1:0] o_bod_sleep_mode,
    output logic [3:0] o_default_clock_source,
    output logic [1:0] o_crc_check_region,
    output logic o_crc_polynomial_select,
    output logic o_crc_scan_enable,
    output logic o_reset_pin_function,
    output logic o_eeprom_erase,
    output logic o_cpu_release
);
    fcl_byte_t watchdog_fuse;
    fcl_byte_t brownout_fuse;
    fcl_byte_t oscillator_fuse;
    fcl_byte_t system_fuse_zero;
    fcl_state_e state_r;
    fcl_state_e state_nxt;
    logic retain_r;

    // Only the programmer can write, and not while the device is locked.
    wire logic prog_write = i_prog_we && !i_locked;

    fcl_fuse_byte #(.FACTORY(`FCL_FACTORY_WDT), .VALID_MASK(`FCL_VALID_WDT), .ADDR(`FCL_OFS_WDT)) u_wdt (
        .i_ref_clk(i_ref_clk),
        .i_nv_init(i_nv_init),
        .i_we(prog_write),
        .i_addr(i_prog_addr),
        .i_wdata(i_prog_wdata),
        .o_value(watchdog_fuse)
    );
    fcl_fuse_byte #(.FACTORY(`FCL_FACTORY_BOD), .VALID_MASK(`FCL_VALID_BOD), .ADDR(`FCL_OFS_BOD)) u_bod (
        .i_ref_clk(i_ref_clk),
        .i_nv_init(i_nv_init),
        .i_we(prog_write),
        .i_addr(i_prog_addr),
        .i_wdata(i_prog_wdata),
        .o_value(brownout_fuse)
    );
    fcl_fuse_byte #(.FACTORY(`FCL_FACTORY_OSC), .VALID_MASK(`FCL_VALID_OSC), .ADDR(`FCL_OFS_OSC)) u_osc (
        .i_ref_clk(i_ref_clk),
        .i_nv_init(i_nv_init),
        .i_we(prog_write),
        .i_addr(i_prog_addr),
        .i_wdata(i_prog_wdata),
        .o_value(oscillator_fuse)
    );
    fcl_fuse_byte #(.FACTORY(`FCL_FACTORY_SYS0), .VALID_MASK(`FCL_VALID_SYS0), .ADDR(`FCL_OFS_SYS0)) u_sys0 (
        .i_ref_clk(i_ref_clk),
        .i_nv_init(i_nv_init),
        .i_we(prog_write),
        .i_addr(i_prog_addr),
        .i_wdata(i_prog_wdata),
        .o_value(system_fuse_zero)
    );

    // Read decode shared by both read ports; unmapped offsets read as zero.
    function automatic fcl_byte_t fuse_read(input fcl_addr_t addr, input fcl_byte_t wdt, input fcl_byte_t bod,
                                            input fcl_byte_t osc, input fcl_byte_t sys0);
        fcl_byte_t val;
        val = `FCL_READ_NONE;
        case (addr)
            `FCL_OFS_WDT: val = wdt;
            `FCL_OFS_BOD: val = bod;
            `FCL_OFS_OSC: val = osc;
            `FCL_OFS_SYS0: val = sys0;
            default: val = `FCL_READ_NONE;
        endcase
        return val;
    endfunction : fuse_read

    wire fcl_byte_t cpu_sel = fuse_read(i_cpu_addr, watchdog_fuse, brownout_fuse, oscillator_fuse, system_fuse_zero);
    wire fcl_byte_t prog_sel = fuse_read(i_prog_addr, watchdog_fuse, brownout_fuse, oscillator_fuse, system_fuse_zero);
    wire fcl_byte_t prog_rd_nxt = i_locked ? `FCL_READ_NONE : prog_sel;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cpu_rdata <= 8'h00;
            o_prog_rdata <= 8'h00;
        end else begin
            if (i_cpu_rd) begin
                o_cpu_rdata <= cpu_sel;
            end
            if (i_prog_rd) begin
                o_prog_rdata <= prog_rd_nxt;
            end
        end
    end

    // Start-up walk: one fuse byte per cycle, then the CPU is let go.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FCL_ST_WDT: state_nxt = FCL_ST_BOD;
            FCL_ST_BOD: state_nxt = FCL_ST_OSC;
            FCL_ST_OSC: state_nxt = FCL_ST_SYS;
            FCL_ST_SYS: state_nxt = FCL_ST_DONE;
            FCL_ST_DONE: state_nxt = FCL_ST_DONE;
            default: state_nxt = FCL_ST_DONE;
        endcase
    end

    wire logic load_wdt = (state_r == FCL_ST_WDT);
    wire logic load_bod = (state_r == FCL_ST_BOD);
    wire logic load_osc = (state_r == FCL_ST_OSC);
    wire logic load_sys = (state_r == FCL_ST_SYS);
    wire logic crc_enable_nxt = (system_fuse_zero[`FCL_SYS_CRC_REGION] != `FCL_SKIP_CHECK);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= FCL_ST_WDT;
            o_cpu_release <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (load_sys) begin
                o_cpu_release <= 1'b1;
            end
        end
    end

    // Target fields change only inside the walk, so later fuse writes wait for a reset.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wdt_window <= 4'h0;
            o_wdt_period <= 4'h0;
        end else if (load_wdt) begin
            o_wdt_window <= watchdog_fuse[`FCL_WDT_WINDOW];
            o_wdt_period <= watchdog_fuse[`FCL_WDT_PERIOD];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_brownout_threshold <= 3'h0;
            o_brownout_sample_rate <= 1'b0;
            o_bod_active_mode <= 2'h0;
            o_bod_sleep_mode <= 2'h0;
        end else if (load_bod) begin
            o_brownout_threshold <= brownout_fuse[`FCL_BOD_THRESHOLD];
            o_brownout_sample_rate <= brownout_fuse[`FCL_BOD_SAMPLE_RATE];
            o_bod_active_mode <= brownout_fuse[`FCL_BOD_ACTIVE];
            o_bod_sleep_mode <= brownout_fuse[`FCL_BOD_SLEEP];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_default_clock_source <= 4'h0;
        end else if (load_osc) begin
            o_default_clock_source <= oscillator_fuse[`FCL_OSC_CLOCK_SOURCE];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_crc_check_region <= 2'h0;
            o_crc_polynomial_select <= 1'b0;
            o_crc_scan_enable <= 1'b0;
            o_reset_pin_function <= 1'b0;
            retain_r <= 1'b0;
        end else if (load_sys) begin
            o_crc_check_region <= system_fuse_zero[`FCL_SYS_CRC_REGION];
            o_crc_polynomial_select <= system_fuse_zero[`FCL_SYS_CRC_POLY];
            o_crc_scan_enable <= crc_enable_nxt;
            o_reset_pin_function <= system_fuse_zero[`FCL_SYS_RESET_PIN];
            retain_r <= system_fuse_zero[`FCL_SYS_EEPROM_RETAIN];
        end
    end

    fcl_erase_ctrl u_erase (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_chip_erase(i_chip_erase),
        .i_locked(i_locked),
        .i_retain(retain_r),
        .o_eeprom_erase(o_eeprom_erase)
    );

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    property p_wdt_window;
        load_wdt |=> (o_wdt_window == $past(watchdog_fuse[`FCL_WDT_WINDOW]));
    endproperty
    a_wdt_window: assert property (p_wdt_window) else $error("Watchdog window not copied.");

    property p_wdt_period;
        load_wdt |=> (o_wdt_period == $past(watchdog_fuse[`FCL_WDT_PERIOD]));
    endproperty
    a_wdt_period: assert property (p_wdt_period) else $error("Watchdog period not copied.");

    property p_bod_threshold;
        load_bod |=> (o_brownout_threshold == $past(brownout_fuse[`FCL_BOD_THRESHOLD]));
    endproperty
    a_bod_threshold: assert property (p_bod_threshold) else $error("Brown-out threshold not copied.");

    property p_bod_modes;
        load_bod |=> (o_brownout_sample_rate == $past(brownout_fuse[`FCL_BOD_SAMPLE_RATE]))
            && (o_bod_active_mode == $past(brownout_fuse[`FCL_BOD_ACTIVE]))
            && (o_bod_sleep_mode == $past(brownout_fuse[`FCL_BOD_SLEEP]));
    endproperty
    a_bod_modes: assert property (p_bod_modes) else $error("Brown-out modes not copied.");

    property p_clock_source;
        load_osc |=> (o_default_clock_source == $past(oscillator_fuse[`FCL_OSC_CLOCK_SOURCE]));
    endproperty
    a_clock_source: assert property (p_clock_source) else $error("Clock source not copied.");

    property p_crc_setup;
        load_sys |=> (o_crc_check_region == $past(system_fuse_zero[`FCL_SYS_CRC_REGION]))
            && (o_crc_scan_enable == (o_crc_check_region != `FCL_SKIP_CHECK))
            && (o_crc_polynomial_select == $past(system_fuse_zero[`FCL_SYS_CRC_POLY]));
    endproperty
    a_crc_setup: assert property (p_crc_setup) else $error("CRC scanner setup wrong.");

    property p_reset_pin;
        load_sys |=> (o_reset_pin_function == $past(system_fuse_zero[`FCL_SYS_RESET_PIN]));
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("Reset pin function not copied.");

    property p_fuse_hold;
        (!prog_write && !i_nv_init) |=> $stable(watchdog_fuse) && $stable(brownout_fuse)
            && $stable(oscillator_fuse) && $stable(system_fuse_zero);
    endproperty
    a_fuse_hold: assert property (p_fuse_hold) else $error("Fuse changed without programmer write.");

    property p_locked_read;
        (i_prog_rd && i_locked) |=> (o_prog_rdata == `FCL_READ_NONE);
    endproperty
    a_locked_read: assert property (p_locked_read) else $error("Locked programmer read returned data.");

    property p_no_late_change;
        o_cpu_release |=> $stable(o_wdt_window) && $stable(o_wdt_period) && $stable(o_bod_active_mode)
            && $stable(o_default_clock_source) && $stable(o_crc_check_region) && $stable(o_reset_pin_function);
    endproperty
    a_no_late_change: assert property (p_no_late_change) else $error("Target changed after start-up.");

    sequence s_load_walk;
        load_bod ##1 load_osc ##1 load_sys ##1 o_cpu_release;
    endsequence
    property p_load_walk;
        (load_wdt && !o_cpu_release) |=> s_load_walk;
    endproperty
    a_load_walk: assert property (p_load_walk) else $error("Start-up walk out of order.");

    property p_release_late;
        !o_cpu_release |-> (state_r != FCL_ST_DONE);
    endproperty
    a_release_late: assert property (p_release_late) else $error("Walk done but CPU held.");
endmodule : fcl_loader

// ---- dv/fcl_periph_model.sv ----
// Peripheral-side model: the control fields that the watchdog, brown-out, clock and CRC logic hold.
// Assumes the loader's fields are valid when its release output rises; erase pulses are counted.
`timescale 1ns/100ps
module fcl_periph_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_release,
    input wire logic [24:0] i_fields,
    input wire logic i_eeprom_erase,
    output logic [24:0] o_applied,
    output logic [7:0] o_wipe_count
);
    logic release_d_r;

    // The peripherals take their fields once, when the start-up copy completes.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            release_d_r <= 1'b0;
            o_applied <= 25'h0;
        end else begin
            release_d_r <= i_release;
            if (i_release && !release_d_r) begin
                o_applied <= i_fields;
            end
        end
    end

    // The EEPROM counts every erase it receives; it keeps its count over reset.
    initial o_wipe_count = 8'h00;
    always @(posedge i_ref_clk) begin
        if (i_eeprom_erase) begin
            o_wipe_count <= o_wipe_count + 8'h01;
        end
    end
endmodule : fcl_periph_model

// ---- dv/test_fuse_config_loader.sv ----
// Self-checking bench for the fuse loader; the bench plays programmer, CPU and erase logic.
// Assumes the loader sources, package and defines header are compiled before this file.
`timescale 1ns/100ps
`include "fcl_defines.svh"
module test_fuse_config_loader;
    import fcl_pkg::*;
    localparam int T = 100;
    logic i_ref_clk, i_rst, i_nv_init, i_locked, i_prog_we, i_prog_rd, i_cpu_rd, i_chip_erase;
    fcl_addr_t i_prog_addr, i_cpu_addr;
    fcl_byte_t i_prog_wdata, o_prog_rdata, o_cpu_rdata;
    logic [3:0] o_wdt_window, o_wdt_period, o_default_clock_source;
    logic [2:0] o_brownout_threshold;
    logic [1:0] o_bod_active_mode, o_bod_sleep_mode, o_crc_check_region;
    logic o_brownout_sample_rate, o_crc_polynomial_select, o_crc_scan_enable;
    logic o_reset_pin_function, o_eeprom_erase, o_cpu_release;
    logic [24:0] fields, applied, prev;
    logic [7:0] wipes;
    logic [31:0] note_q[$];
    logic cpu_rd_d, prog_rd_d, erase_d, rel_d;
    int failures, cmp_count, rel_cnt, exp_wipes;
    fcl_byte_t img[4];
    fcl_addr_t ofs[4] = '{`FCL_OFS_WDT, `FCL_OFS_BOD, `FCL_OFS_OSC, `FCL_OFS_SYS0};
    fcl_byte_t msk[4] = '{`FCL_VALID_WDT, `FCL_VALID_BOD, `FCL_VALID_OSC, `FCL_VALID_SYS0};

    fcl_loader dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_nv_init(i_nv_init), .i_locked(i_locked),
        .i_prog_we(i_prog_we), .i_prog_addr(i_prog_addr), .i_prog_wdata(i_prog_wdata), .i_prog_rd(i_prog_rd),
        .i_cpu_rd(i_cpu_rd), .i_cpu_addr(i_cpu_addr), .i_chip_erase(i_chip_erase), .o_prog_rdata(o_prog_rdata),
        .o_cpu_rdata(o_cpu_rdata), .o_wdt_window(o_wdt_window), .o_wdt_period(o_wdt_period),
        .o_brownout_threshold(o_brownout_threshold), .o_brownout_sample_rate(o_brownout_sample_rate),
        .o_bod_active_mode(o_bod_active_mode), .o_bod_sleep_mode(o_bod_sleep_mode),
        .o_default_clock_source(o_default_clock_source), .o_crc_check_region(o_crc_check_region),
        .o_crc_polynomial_select(o_crc_polynomial_select), .o_crc_scan_enable(o_crc_scan_enable),
        .o_reset_pin_function(o_reset_pin_function), .o_eeprom_erase(o_eeprom_erase),
        .o_cpu_release(o_cpu_release));

    assign fields = {o_wdt_window, o_wdt_period, o_brownout_threshold, o_brownout_sample_rate,
        o_bod_active_mode, o_bod_sleep_mode, o_default_clock_source, o_crc_check_region,
        o_crc_polynomial_select, o_crc_scan_enable, o_reset_pin_function};

    fcl_periph_model peer_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_release(o_cpu_release), .i_fields(fields),
        .i_eeprom_erase(o_eeprom_erase), .o_applied(applied), .o_wipe_count(wipes));

    initial begin
        i_ref_clk = 1'b0;
        forever #(T / 2) i_ref_clk = ~i_ref_clk;
    end

    function automatic logic [24:0] exp_fields();
        return {img[0], img[1], img[2][3:0], img[3][7:6], img[3][5], img[3][7:6] != `FCL_SKIP_CHECK, img[3][3]};
    endfunction : exp_fields

    function automatic fcl_byte_t exp_read(input fcl_addr_t a);
        fcl_byte_t v;
        v = `FCL_READ_NONE;
        for (int i = 0; i < 4; i++) begin
            if (ofs[i] == a) v = img[i];
        end
        return v;
    endfunction : exp_read

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic take(input logic [31:0] seen);
        if (note_q.size() == 0) check(seen, 32'hffff_ffff);
        else check(seen, note_q.pop_front());
    endtask : take

    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask : tick

    // Writes all four fuse bytes back to back, reserved bits cleared.
    task automatic prog_all();
        for (int i = 0; i < 4; i++) begin
            i_prog_we = 1'b1;
            i_prog_addr = ofs[i];
            i_prog_wdata = img[i] & msk[i];
            img[i] = img[i] & msk[i];
            tick();
        end
        i_prog_we = 1'b0;
        tick();
    endtask : prog_all

    task automatic cpu_read(input fcl_addr_t a);
        note_q.push_back({24'h0, exp_read(a)});
        i_cpu_rd = 1'b1;
        i_cpu_addr = a;
        tick();
        i_cpu_rd = 1'b0;
        tick();
    endtask : cpu_read

    task automatic prog_read(input fcl_addr_t a);
        note_q.push_back({24'h0, i_locked ? `FCL_READ_NONE : exp_read(a)});
        i_prog_rd = 1'b1;
        i_prog_addr = a;
        tick();
        i_prog_rd = 1'b0;
        tick();
    endtask : prog_read

    task automatic chip_erase(input logic lock, input logic retain);
        i_locked = lock;
        note_q.push_back({31'h0, lock | !retain});
        if (lock || !retain) exp_wipes++;
        i_chip_erase = 1'b1;
        tick();
        i_chip_erase = 1'b0;
        tick();
        i_locked = 1'b0;
        tick();
    endtask : chip_erase

    task automatic do_reset(input int n);
        note_q.push_back({7'h0, exp_fields()});
        i_rst = 1'b1;
        repeat (n) tick();
        i_rst = 1'b0;
        repeat (6) tick();
    endtask : do_reset

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            {cpu_rd_d, prog_rd_d, erase_d, rel_d} <= 4'h0;
            rel_cnt <= 0;
        end else begin
            {cpu_rd_d, prog_rd_d, erase_d, rel_d} <= {i_cpu_rd, i_prog_rd, i_chip_erase, o_cpu_release};
            rel_cnt <= rel_cnt + 1;
        end
    end

    always @(negedge i_ref_clk) begin
        if (!i_rst) begin
            if (cpu_rd_d) take({24'h0, o_cpu_rdata});
            if (prog_rd_d) take({24'h0, o_prog_rdata});
            if (erase_d) take({31'h0, o_eeprom_erase});
            if (o_cpu_release && !rel_d) begin
                take({7'h0, fields});
                check(rel_cnt, 4);
            end
        end
    end

    task automatic end_sim();
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    initial begin
        #(T * 5000);
        failures++;
        end_sim();
    end

    initial begin
        logic [2:0] k;
        logic old_retain;
        {i_rst, i_nv_init, i_locked, i_prog_we, i_prog_rd, i_cpu_rd, i_chip_erase} = 7'h60;
        {i_prog_addr, i_cpu_addr, i_prog_wdata} = 16'h0;
        void'($urandom(32'hc5cd));
        img = '{`FCL_FACTORY_WDT, `FCL_FACTORY_BOD, `FCL_FACTORY_OSC, `FCL_FACTORY_SYS0};
        note_q.push_back({7'h0, exp_fields()});
        tick();
        i_nv_init = 1'b0;
        repeat (7) tick();
        i_rst = 1'b0;
        repeat (6) tick();
        for (int a = 0; a < 8; a++) cpu_read(4'(a));
        i_prog_we = 1'b1;
        i_prog_addr = 4'h3;
        i_prog_wdata = 8'hff;
        tick();
        i_prog_we = 1'b0;
        cpu_read(4'h3);
        for (int n = 0; n < 8; n++) begin
            k = 3'(n);
            prev = fields;
            old_retain = img[3][0];
            img[0] = 8'($urandom());
            img[1] = {k, k[0], k[1:0], k[1:0]};
            img[2] = {5'h0, k};
            img[3] = {k[1:0], k[2], 1'b0, k[0], 2'h0, k[1]};
            prog_all();
            if (n == 3) begin
                i_locked = 1'b1;
                i_prog_we = 1'b1;
                i_prog_addr = `FCL_OFS_WDT;
                i_prog_wdata = ~img[0];
                tick();
                i_prog_we = 1'b0;
                prog_read(`FCL_OFS_WDT);
            end
            check({7'h0, fields}, {7'h0, prev});
            check({7'h0, applied}, {7'h0, prev});
            chip_erase(1'b0, old_retain);
            do_reset(2);
            check({7'h0, applied}, {7'h0, exp_fields()});
            cpu_read(`FCL_OFS_SYS0);
            prog_read(ofs[k[1:0]]);
            chip_erase(1'b0, img[3][0]);
            chip_erase(1'b1, img[3][0]);
        end
        check({24'h0, wipes}, exp_wipes);
        end_sim();
    end
endmodule : test_fuse_config_loader
